// *** tb/test_two_level_irq_controller.sv ***
`timescale 1ns/1ps
module test_two_level_irq_controller;
	import tlic_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [NUM_SRC-1:0] src_event = 8'h00;
	logic ret_exec = 1'b0;
	logic ce = 1'b1;
	logic hi_active;
	logic lo_active;
	logic [DATA_W-1:0] reg_rdata;
	logic [PC_W-1:0] return_pc;
	logic pc_load;
	logic [PC_W-1:0] pc_vector;
	logic stack_push;
	logic [PC_W-1:0] stack_data;
	int num_errors = 0;
	int samples_checked = 0;

	always #50 clk = ~clk;

	tlic_top i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event), .ret_exec(ret_exec),
		.return_pc(return_pc), .pc_load(pc_load), .pc_vector(pc_vector), .stack_push(stack_push),
		.stack_data(stack_data), .hi_active(hi_active), .lo_active(lo_active));

	tlic_cpu_model i_cpu (.clk(clk), .rst_n(rst_n), .pc_vector(pc_vector), .stack_push(stack_push),
		.stack_data(stack_data), .ret_exec(ret_exec), .return_pc(return_pc));

	// ==========================================================
	// access tasks
	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask

	task automatic ev(input logic [7:0] b);
		@(posedge clk);
		src_event <= b;
		@(posedge clk);
		src_event <= 8'h00;
	endtask

	task automatic ret;
		@(posedge clk);
		ret_exec <= 1'b1;
		@(posedge clk);
		ret_exec <= 1'b0;
	endtask

	// lat 0 skips the latency check for entries not started by a fresh event;
	// n counts edges after the event cycle, so the event cycle itself adds one
	task automatic vec(input logic [15:0] v, input logic [15:0] r, input int lat);
		int n;
		for (n = 1; n < 8; n++) begin
			@(posedge clk);
			#1;
			if (pc_load === 1'b1) break;
		end
		if (n == 8) begin
			num_errors++;
			final_report();
		end else begin
			if (lat != 0) chk(16'(n + 1), 16'(lat));
			chk(pc_vector, v);
			chk(stack_data, r);
			chk({15'h0, stack_push}, 16'h0001);
		end
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			chk({15'h0, pc_load}, 16'h0000);
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(REG_RESET_CTRL, 8'h00);
		rd(REG_IRQ_CTRL, 8'h00);
		rd(REG_PRIO, 8'hff);
		rd(4'h9, 8'h00);
		ev(8'h09);
		quiet(4);
		rd(REG_FLAG, 8'h09);
		wr(REG_IRQ_CTRL, 8'hc0);
		quiet(4);
		// compatibility mode
		wr(REG_FLAG, 8'h00);
		wr(REG_PRIO, 8'h00);
		wr(REG_IRQ_CTRL, 8'h80);
		wr(REG_ENABLE, 8'h09);
		ev(8'h08);
		quiet(4);
		ev(8'h01);
		vec(VEC_HIGH, 16'h0100, LATENCY_CYC);
		rd(REG_IRQ_CTRL, 8'h00);
		wr(REG_FLAG, 8'h00);
		ret();
		rd(REG_IRQ_CTRL, 8'h80);
		wr(REG_IRQ_CTRL, 8'hc0);
		ev(8'h08);
		vec(VEC_HIGH, 16'h0100, LATENCY_CYC);
		wr(REG_FLAG, 8'h00);
		ret();
		// priority mode
		wr(REG_RESET_CTRL, 8'h80);
		wr(REG_PRIO, 8'h01);
		wr(REG_IRQ_CTRL, 8'h40);
		ev(8'h01);
		quiet(4);
		ev(8'h08);
		vec(VEC_LOW, 16'h0100, LATENCY_CYC);
		rd(REG_IRQ_CTRL, 8'h00);
		wr(REG_IRQ_CTRL, 8'h80);
		vec(VEC_HIGH, VEC_LOW, 0);
		rd(REG_STATUS, 8'hc0);
		chk({14'h0, hi_active, lo_active}, 16'h0003);
		rd(REG_IRQ_CTRL, 8'h00);
		wr(REG_IRQ_CTRL, 8'h40);
		quiet(4);
		wr(REG_FLAG, 8'h00);
		ret();
		rd(REG_IRQ_CTRL, 8'hc0);
		rd(REG_STATUS, 8'h40);
		ret();
		rd(REG_STATUS, 8'h00);
		chk({14'h0, hi_active, lo_active}, 16'h0000);
		// a frozen clock enable must swallow an event pulse
		@(posedge clk);
		ce <= 1'b0;
		ev(8'h01);
		@(posedge clk);
		ce <= 1'b1;
		rd(REG_FLAG, 8'h00);
		ev(8'h09);
		vec(VEC_HIGH, 16'h0100, LATENCY_CYC);
		quiet(4);
		rd(REG_STATUS, 8'h80);
		chk({14'h0, hi_active, lo_active}, 16'h0002);
		rd(REG_FLAG, 8'h09);
		final_report();
	end
endmodule

// *** tb/tlic_cpu_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// core side: program counter and return stack
module tlic_cpu_model import tlic_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [PC_W-1:0] pc_vector,
	input wire logic stack_push,
	input wire logic [PC_W-1:0] stack_data,
	input wire logic ret_exec,
	output logic [PC_W-1:0] return_pc
);
	logic [PC_W-1:0] stack_q [4];
	logic [1:0] sp_q;
	// the pc moves only on entries and returns, so every pushed address is an earlier vector or the reset pc
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			return_pc <= 16'h0100;
			sp_q <= 2'h0;
		end else if (stack_push) begin
			stack_q[sp_q] <= stack_data;
			sp_q <= sp_q + 2'h1;
			return_pc <= pc_vector;
		end else if (ret_exec) begin
			sp_q <= sp_q - 2'h1;
			return_pc <= stack_q[sp_q - 2'h1];
		end
	end
endmodule

// *** verilog/tlic_arbiter.sv ***
`timescale 1ns/1ps
module tlic_arbiter import tlic_pkg::*; (
	input wire logic [NUM_SRC-1:0] flags,
	input wire logic [NUM_SRC-1:0] enable,
	input wire logic [NUM_SRC-1:0] prio,
	input wire tlic_ctrl_type ctrl,
	input wire logic hi_active,
	output tlic_pick_type pick
);
	// ==========================================================
	// a source asks only with flag and its own enable set
	function automatic logic any_req(input logic [NUM_SRC-1:0] f, input logic [NUM_SRC-1:0] e,
		input logic [NUM_SRC-1:0] sel);
		any_req = |(f & e & sel);
	endfunction

	wire logic [NUM_SRC-1:0] compat_sel = ~PERIPH_MASK | {NUM_SRC{ctrl.lo_en}};
	wire logic compat_req = ctrl.hi_en && any_req(flags, enable, compat_sel);
	wire logic hi_grp = ctrl.hi_en && any_req(flags, enable, prio);
	wire logic lo_grp = ctrl.lo_en && any_req(flags, enable, ~prio);
	// high wins a tie; low waits while a high handler runs
	wire logic lo_ok = lo_grp && !hi_grp && !hi_active;

	// priority bits are ignored unless priority mode is on
	assign pick.hi = ctrl.prio_en ? hi_grp : compat_req;
	assign pick.lo = ctrl.prio_en && lo_ok;
endmodule

// *** verilog/tlic_flag_bank.sv ***
`timescale 1ns/1ps
module tlic_flag_bank import tlic_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [NUM_SRC-1:0] src_event,
	input wire logic sw_we,
	input wire logic [NUM_SRC-1:0] sw_data,
	output logic [NUM_SRC-1:0] flags
);
	logic [NUM_SRC-1:0] ev_q;
	logic [NUM_SRC-1:0] flag_q;
	logic [NUM_SRC-1:0] flag_d;

	assign flags = flag_q;

	// ==========================================================
	// one sticky flag per source
	genvar i;
	generate
		for (i = 0; i < NUM_SRC; i++) begin : g_src
			// an event landing on a software clear still sets the flag
			assign flag_d[i] = ev_q[i] | (sw_we ? sw_data[i] : flag_q[i]);
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					ev_q[i] <= 1'b0;
					flag_q[i] <= RST_FLAG[i];
				end else if (ce) begin
					ev_q[i] <= src_event[i];
					flag_q[i] <= flag_d[i];
				end
			end
		end
	endgenerate
endmodule

// *** verilog/tlic_pkg.sv ***
package tlic_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_SRC = 8;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	// sources 3..7 count as peripheral sources
	localparam logic [NUM_SRC-1:0] PERIPH_MASK = 8'hf8;

	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] REG_RESET_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_IRQ_CTRL = 4'h1;
	localparam logic [ADDR_W-1:0] REG_FLAG = 4'h2;
	localparam logic [ADDR_W-1:0] REG_ENABLE = 4'h3;
	localparam logic [ADDR_W-1:0] REG_PRIO = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;

	// ==========================================================
	// field positions
	localparam int BIT_PRIO_EN = 7;
	localparam int BIT_HI_EN = 7;
	localparam int BIT_LO_EN = 6;
	localparam int BIT_ST_HI = 7;
	localparam int BIT_ST_LO = 6;
	localparam int BIT_ST_ENTRY = 5;

	// ==========================================================
	// reset values
	localparam logic [DATA_W-1:0] RST_RESET_CTRL = 8'h00;
	localparam logic [DATA_W-1:0] RST_IRQ_CTRL = 8'h00;
	localparam logic [NUM_SRC-1:0] RST_FLAG = 8'h00;
	localparam logic [NUM_SRC-1:0] RST_ENABLE = 8'h00;
	localparam logic [NUM_SRC-1:0] RST_PRIO = 8'hff;

	// ==========================================================
	// vectors and timing
	localparam logic [PC_W-1:0] VEC_HIGH = 16'h0008;
	localparam logic [PC_W-1:0] VEC_LOW = 16'h0018;
	// event edge to vector pulse, in clock cycles
	localparam int LATENCY_CYC = 3;

	// ==========================================================
	// types
	typedef struct packed {
		logic prio_en;
		logic hi_en;
		logic lo_en;
	} tlic_ctrl_type;

	typedef struct packed {
		logic hi;
		logic lo;
	} tlic_pick_type;

	typedef enum logic {ST_RUN, ST_ENTRY} tlic_state_type;
endpackage

// *** verilog/tlic_top.sv ***
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - priority mode: high requests vector to 0008h, low requests to 0018h.
// - a high request preempts a running low handler.
// - each source has a flag, an enable and a priority bit.
// - priority mode only while priority_levels_enable is set; cleared by default.
// - priority mode: high_group_enable gates all high-priority sources.
// - priority mode: low_group_enable gates all low-priority sources.
// - flag, enable and group enable all set sends the core to the vector.
// - compatibility mode ignores every priority bit.
// - compatibility mode: bit 6 gates peripheral sources, bit 7 gates all.
// - compatibility mode: every interrupt goes to 0008h.
// - taking an interrupt clears the group or global enable that applies.
// - no low request is taken while a high handler runs.
// - entry pushes the return address and loads the vector into the PC.
// - return_from_handler sets the enable that applies again.
// - pin events reach the vector in three cycles, fixed.
// - flags set on events regardless of any enable.
// - a cleared source enable blocks that source even with its flag set.
module tlic_top import tlic_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [NUM_SRC-1:0] src_event,
	input wire logic ret_exec,
	input wire logic [PC_W-1:0] return_pc,
	output logic pc_load,
	output logic [PC_W-1:0] pc_vector,
	output logic stack_push,
	output logic [PC_W-1:0] stack_data,
	output logic hi_active,
	output logic lo_active
);
	// ==========================================================
	// state
	tlic_ctrl_type ctrl_q;
	tlic_ctrl_type ctrl_d;
	tlic_state_type state_q;
	tlic_state_type state_d;
	logic [NUM_SRC-1:0] enable_q;
	logic [NUM_SRC-1:0] prio_q;
	logic hi_act_q;
	logic hi_act_d;
	logic lo_act_q;
	logic lo_act_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic pc_load_q;
	logic [PC_W-1:0] vec_q;
	logic [PC_W-1:0] vec_d;
	logic push_q;
	logic [PC_W-1:0] sdata_q;
	logic [NUM_SRC-1:0] flags;
	tlic_pick_type pick;

	// ==========================================================
	// register decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	wire logic wr_rc = reg_wr && hit(reg_addr, REG_RESET_CTRL);
	wire logic wr_ic = reg_wr && hit(reg_addr, REG_IRQ_CTRL);
	wire logic wr_flag = reg_wr && hit(reg_addr, REG_FLAG);
	wire logic wr_en = reg_wr && hit(reg_addr, REG_ENABLE);
	wire logic wr_prio = reg_wr && hit(reg_addr, REG_PRIO);

	logic [DATA_W-1:0] rc_view;
	logic [DATA_W-1:0] ic_view;
	logic [DATA_W-1:0] st_view;

	// each view places its bits at the package field positions; the rest read zero
	always_comb begin
		rc_view = 8'h00;
		ic_view = 8'h00;
		st_view = 8'h00;
		rc_view[BIT_PRIO_EN] = ctrl_q.prio_en;
		ic_view[BIT_HI_EN] = ctrl_q.hi_en;
		ic_view[BIT_LO_EN] = ctrl_q.lo_en;
		st_view[BIT_ST_HI] = hi_act_q;
		st_view[BIT_ST_LO] = lo_act_q;
		st_view[BIT_ST_ENTRY] = (state_q == ST_ENTRY);
	end

	// unmapped offsets read as zero; a read has no side effect
	always_comb begin
		rdata_d = 8'h00;
		if (!reg_rd) begin
			rdata_d = 8'h00;
		end else if (hit(reg_addr, REG_RESET_CTRL)) begin
			rdata_d = rc_view;
		end else if (hit(reg_addr, REG_IRQ_CTRL)) begin
			rdata_d = ic_view;
		end else if (hit(reg_addr, REG_FLAG)) begin
			rdata_d = flags;
		end else if (hit(reg_addr, REG_ENABLE)) begin
			rdata_d = enable_q;
		end else if (hit(reg_addr, REG_PRIO)) begin
			rdata_d = prio_q;
		end else if (hit(reg_addr, REG_STATUS)) begin
			rdata_d = st_view;
		end
	end

	// ==========================================================
	// flags and arbitration
	tlic_flag_bank u_flags (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.src_event(src_event),
		.sw_we(wr_flag),
		.sw_data(reg_wdata),
		.flags(flags)
	);

	tlic_arbiter u_arb (
		.flags(flags),
		.enable(enable_q),
		.prio(prio_q),
		.ctrl(ctrl_q),
		.hi_active(hi_act_q),
		.pick(pick)
	);

	// decisions are made only between entries, so one entry is one pulse
	wire logic run = (state_q == ST_RUN);
	wire logic take_hi = run && pick.hi;
	wire logic take_lo = run && pick.lo;
	wire logic take = take_hi || take_lo;
	wire logic ret_hi = ret_exec && ctrl_q.prio_en && hi_act_q;
	wire logic ret_lo = ret_exec && ctrl_q.prio_en && !hi_act_q && lo_act_q;

	// ==========================================================
	// global enables: software write, then return, then entry clear
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_rc) begin
			ctrl_d.prio_en = reg_wdata[BIT_PRIO_EN];
		end
		if (wr_ic) begin
			ctrl_d.hi_en = reg_wdata[BIT_HI_EN];
			ctrl_d.lo_en = reg_wdata[BIT_LO_EN];
		end
		if (ret_exec) begin
			if (ret_lo) begin
				ctrl_d.lo_en = 1'b1;
			end else begin
				ctrl_d.hi_en = 1'b1;
			end
		end
		// hardware clear beats a software write in the same cycle
		if (take_hi) begin
			ctrl_d.hi_en = 1'b0;
		end
		if (take_lo) begin
			ctrl_d.lo_en = 1'b0;
		end
	end

	// ==========================================================
	// handler nesting: high may sit on top of low, never the reverse
	always_comb begin
		hi_act_d = hi_act_q;
		lo_act_d = lo_act_q;
		if (ret_hi) begin
			hi_act_d = 1'b0;
		end else if (ret_lo) begin
			lo_act_d = 1'b0;
		end
		if (take_hi && ctrl_q.prio_en) begin
			hi_act_d = 1'b1;
		end
		if (take_lo) begin
			lo_act_d = 1'b1;
		end
	end

	// the entry cycle makes no decision, so entries stand at least two cycles apart
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (take) begin
					state_d = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	// compatibility mode only ever raises take_hi
	assign vec_d = take_lo ? VEC_LOW : VEC_HIGH;

	// ==========================================================
	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= '{prio_en: RST_RESET_CTRL[BIT_PRIO_EN], hi_en: RST_IRQ_CTRL[BIT_HI_EN],
				lo_en: RST_IRQ_CTRL[BIT_LO_EN]};
			enable_q <= RST_ENABLE;
			prio_q <= RST_PRIO;
			hi_act_q <= 1'b0;
			lo_act_q <= 1'b0;
			state_q <= ST_RUN;
		end else if (ce) begin
			ctrl_q <= ctrl_d;
			enable_q <= wr_en ? reg_wdata : enable_q;
			prio_q <= wr_prio ? reg_wdata : prio_q;
			hi_act_q <= hi_act_d;
			lo_act_q <= lo_act_d;
			state_q <= state_d;
		end
	end

	// entry: vector and return address leave together, one cycle each
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_load_q <= 1'b0;
			push_q <= 1'b0;
			vec_q <= VEC_HIGH;
			sdata_q <= 16'h0000;
			rdata_q <= 8'h00;
		end else if (ce) begin
			pc_load_q <= take;
			push_q <= take;
			vec_q <= take ? vec_d : vec_q;
			sdata_q <= take ? return_pc : sdata_q;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign pc_load = pc_load_q;
	assign pc_vector = vec_q;
	assign stack_push = push_q;
	assign stack_data = sdata_q;
	assign hi_active = hi_act_q;
	assign lo_active = lo_act_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_hi_entry;
		ce && take_hi;
	endsequence

	sequence s_quiet_pin0;
		ce && src_event[0] && enable_q[0] && prio_q[0] && ctrl_q.prio_en && ctrl_q.hi_en
			&& !hi_act_q && run && !reg_wr && !ret_exec
			##1 (ce && !reg_wr && !pc_load_q && !ret_exec) [*2];
	endsequence

	sequence s_ret_high;
		ce && ret_hi && !take_hi && !wr_ic;
	endsequence

	sequence s_ret_low;
		ce && ret_lo && !take_lo && !wr_ic;
	endsequence

	AST_VEC_HIGH: assert property (s_hi_entry |=> pc_load_q && stack_push && pc_vector == VEC_HIGH)
		else $error("high entry did not load vector 0008h");

	AST_VEC_LOW: assert property (ce && take_lo |=> pc_load_q && pc_vector == VEC_LOW && lo_act_q)
		else $error("low entry did not load vector 0018h");

	AST_PUSH_ADDR: assert property (ce && take ##1 1 |-> stack_data == $past(return_pc))
		else $error("pushed address is not the return address");

	AST_CLEAR_HI: assert property (s_hi_entry and ctrl_q.prio_en |=> !ctrl_q.hi_en && hi_act_q)
		else $error("high group enable not cleared on entry");

	AST_CLEAR_LO: assert property (ce && take_lo |=> !ctrl_q.lo_en)
		else $error("low group enable not cleared on entry");

	AST_COMPAT_ONE_VEC: assert property (!ctrl_q.prio_en |-> !take_lo)
		else $error("low vector used in compatibility mode");

	AST_NO_LOW_IN_HIGH: assert property (hi_act_q |-> !take_lo)
		else $error("low request taken inside a high handler");

	AST_HIGH_FIRST: assert property (ctrl_q.prio_en && pick.hi |-> !take_lo)
		else $error("low taken while high request pending");

	AST_PREEMPT: assert property (ce && lo_act_q && take_hi && ctrl_q.prio_en |=> hi_act_q && lo_act_q)
		else $error("high preemption lost low nesting");

	AST_RET_COMPAT: assert property (ce && ret_exec && !ctrl_q.prio_en && !take_hi && !wr_ic |=> ctrl_q.hi_en)
		else $error("return did not set global enable");

	AST_RET_LOW: assert property (s_ret_low |=> ctrl_q.lo_en && !lo_act_q)
		else $error("return from low handler did not set low enable");

	AST_EN_GATE: assert property ((flags & enable_q) == 8'h00 |-> !take)
		else $error("entry without an enabled flag");

	AST_PERIPH_GATE: assert property (!ctrl_q.prio_en && !ctrl_q.lo_en
		&& (flags & enable_q & ~PERIPH_MASK) == 8'h00 |-> !take_hi)
		else $error("peripheral source passed a cleared peripheral enable");

	AST_FLAG_POLL: assert property (ce && src_event[0] ##1 ce |=> flags[0])
		else $error("event did not set its flag");

	AST_LATENCY: assert property (s_quiet_pin0 |=> pc_load_q)
		else $error("pin event did not vector within three cycles");

	AST_RET_HIGH: assert property (s_ret_high |=> ctrl_q.hi_en && !hi_act_q)
		else $error("return from high handler did not set high enable");

	AST_ENTRY_ONE: assert property (ce && pc_load_q |=> !pc_load_q)
		else $error("vector load lasted more than one cycle");

	AST_VEC_HOLD: assert property (ce && !take |=> $stable(pc_vector))
		else $error("vector changed without an entry");

	AST_FLAG_STICKY: assert property (ce && !wr_flag |=> (flags & $past(flags)) == $past(flags))
		else $error("flag dropped without a software write");

	AST_FLAG_READ: assert property (ce && reg_rd && reg_addr == REG_FLAG |=> reg_rdata == $past(flags))
		else $error("flag read did not return the flags");

	AST_COMPAT_TAKE: assert property (!ctrl_q.prio_en && ctrl_q.hi_en && run
		&& (flags & enable_q & ~PERIPH_MASK) != 8'h00 |-> take_hi)
		else $error("eligible request ignored in compatibility mode");

	AST_HI_TAKE: assert property (ctrl_q.prio_en && ctrl_q.hi_en && run
		&& (flags & enable_q & prio_q) != 8'h00 |-> take_hi)
		else $error("eligible high request ignored");

	AST_LO_TAKE: assert property (ctrl_q.prio_en && ctrl_q.lo_en && run && !hi_act_q && !pick.hi
		&& (flags & enable_q & ~prio_q) != 8'h00 |-> take_lo)
		else $error("eligible low request ignored");

	AST_LO_PENDING: assert property (ce && take_hi && ctrl_q.prio_en && ctrl_q.lo_en && !reg_wr
		&& (flags & enable_q & ~prio_q) != 8'h00 |=> ctrl_q.lo_en && (flags & enable_q & ~prio_q) != 8'h00)
		else $error("low request lost when high was taken first");
endmodule
